// ===== hdl/fault_flags.sv
// Sticky fault status bits with paired status and clear write
`timescale 1ns/1ns
module fault_flags
    import led_regs_pkg::*;
#(
    parameter int GROUPS = 3,
    parameter int FLAGS  = 8
) (
    // Clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    rstn_i,
    // Events and writes
    input  wire logic [GROUPS*FLAGS-1:0] evt_i,
    input  wire logic [GROUPS-1:0]       wr_i,
    input  wire logic [15:0]             wdata_i,
    // Status
    output logic [GROUPS*FLAGS-1:0]      flags_o
);
    if (FLAGS > FLAG_MAX) begin : g_bad_flags
        $error("fault_flags: FLAGS must not exceed the clear field width");
    end

    for (genvar g = 0; g < GROUPS; g++) begin : g_grp
        for (genvar f = 0; f < FLAGS; f++) begin : g_bit
            localparam int K = g * FLAGS + f;
            logic clr;
            assign clr = wr_i[g] & wdata_i[f] & wdata_i[CLR_LSB + f];

            // A new event in the clearing cycle wins over the clear
            always_ff @(posedge mclk_i) begin
                if (!rstn_i) begin
                    flags_o[K] <= 1'b0;
                end else if (evt_i[K]) begin
                    flags_o[K] <= 1'b1;
                end else if (clr) begin
                    flags_o[K] <= 1'b0;
                end
            end

            AST_FLAG_CLEAR: assert property (@(posedge mclk_i) disable iff (!rstn_i)
                flags_o[K] && wr_i[g] && !(wdata_i[f] && wdata_i[CLR_LSB + f])
                |=> flags_o[K])
                else $error("fault flag cleared without status and clear bits");
        end
    end

endmodule : fault_flags

// ===== hdl/i2c_byte_engine.sv
// Bit level serial slave: framing, byte shifting and acknowledge drive
`timescale 1ns/1ns
module i2c_byte_engine
    import led_regs_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    // Serial pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oen_o,
    // Byte side
    input  wire logic       ack_i,
    input  wire logic       tx_en_i,
    input  wire logic [7:0] tx_byte_i,
    output logic            start_o,
    output logic            stop_o,
    output logic [7:0]      byte_o,
    output logic            byte_vld_o,
    output logic            mack_o,
    output logic            mnack_o
);
    logic       scl_q;
    logic       sda_q;
    logic       frame_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic       drive_r;
    logic       tx_act_r;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;

    assign scl_rise  = scl_i & ~scl_q;
    assign scl_fall  = ~scl_i & scl_q;
    assign start_det = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_det  = scl_i & scl_q & ~sda_q & sda_i;
    // Open drain: only ever pulls low
    assign sda_o     = 1'b0;
    assign sda_oen_o = ~drive_r;

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            frame_r   <= 1'b0;
            bit_cnt_r <= 4'h0;
            shift_r   <= 8'h00;
        end else if (start_det) begin
            frame_r   <= 1'b1;
            bit_cnt_r <= 4'h0;
        end else if (stop_det) begin
            frame_r   <= 1'b0;
        end else if (frame_r && scl_rise) begin
            if (bit_cnt_r == ACK_SLOT) begin
                bit_cnt_r <= 4'h0;
            end else begin
                shift_r   <= {shift_r[6:0], sda_i};
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            start_o    <= 1'b0;
            stop_o     <= 1'b0;
            byte_vld_o <= 1'b0;
            byte_o     <= 8'h00;
            mack_o     <= 1'b0;
            mnack_o    <= 1'b0;
        end else begin
            start_o    <= start_det;
            stop_o     <= stop_det;
            byte_vld_o <= frame_r & scl_rise & (bit_cnt_r == LAST_BIT);
            if (frame_r && scl_rise && bit_cnt_r == LAST_BIT) begin
                byte_o <= {shift_r[6:0], sda_i};
            end
            mack_o     <= frame_r & scl_rise & (bit_cnt_r == ACK_SLOT) & tx_act_r & ~sda_i;
            mnack_o    <= frame_r & scl_rise & (bit_cnt_r == ACK_SLOT) & tx_act_r & sda_i;
        end
    end

    // Pin changes only while the clock line is low, so no false start or stop
    // Direction is latched per byte, so the address ack of a read is still ours
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            drive_r  <= 1'b0;
            tx_act_r <= 1'b0;
            tx_r     <= 8'h00;
        end else if (start_det || stop_det) begin
            drive_r  <= 1'b0;
            tx_act_r <= 1'b0;
        end else if (frame_r && scl_fall) begin
            if (bit_cnt_r == ACK_SLOT) begin
                drive_r <= ~tx_act_r & ack_i;
            end else if (bit_cnt_r == 4'h0) begin
                tx_act_r <= tx_en_i;
                drive_r  <= tx_en_i & ~tx_byte_i[7];
                tx_r     <= {tx_byte_i[6:0], 1'b0};
            end else if (tx_act_r) begin
                drive_r <= ~tx_r[7];
                tx_r    <= {tx_r[6:0], 1'b0};
            end else begin
                drive_r <= 1'b0;
            end
        end
    end

endmodule : i2c_byte_engine

// ===== hdl/led_driver_register_map.sv
// Register bank of a four channel LED driver, reached over the serial slave port
`timescale 1ns/1ns
// Contract
// - Sixteen 16-bit registers at even offsets 00h-1Eh
// - Brightness word at 00h, resets to zero
// - 12-bit global current in bits 11-0
// - Current register resets to 0FFFh
// - Configuration one at 04h resets to 8A3h
// - Write is address, register, high, low bytes
// - Source 0 selects PWM, 2 selects register
// - Fault clears only with status and clear
module led_driver_register_map
    import led_regs_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = SLAVE_DEF,
    parameter int         FLAGS      = 8
) (
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rstn_i,
    // Serial pins
    input  wire logic             scl_i,
    input  wire logic             sda_i,
    output logic                  sda_o,
    output logic                  sda_oen_o,
    // Fault events
    input  wire logic [FLAGS-1:0] supply_fault_evt_i,
    input  wire logic [FLAGS-1:0] boost_fault_evt_i,
    input  wire logic [FLAGS-1:0] led_fault_evt_i,
    // Measured and diagnostic values
    input  wire logic [15:0]      pwm_duty_i,
    input  wire logic [15:0]      diag_state_i,
    input  wire logic [15:0]      diag_pwm_out_i,
    input  wire logic [15:0]      diag_current_i,
    input  wire logic [15:0]      diag_boost_i,
    input  wire logic [15:0]      diag_detect_i,
    // Control outputs
    output logic [15:0]           brightness_o,
    output logic [11:0]           global_current_setting_o,
    output logic [1:0]            brightness_source_select_o,
    output logic                  smooth_sloping_on_o,
    output logic [1:0]            spread_rate_select_o,
    output logic [15:0]           config_one_o,
    output logic [15:0]           config_two_o,
    // Interrupt enables and fault status
    output logic [15:0]           supply_int_en_o,
    output logic [15:0]           boost_int_en_o,
    output logic [15:0]           led_interrupt_enable_o,
    output logic [3*FLAGS-1:0]    fault_flags_o
);
    // ==========================================================
    // Serial byte engine
    logic       start;
    logic       stop;
    logic [7:0] rx_byte;
    logic       byte_vld;
    logic       mack;
    logic       mnack;
    logic       ack_r;
    logic       tx_en_r;
    logic [7:0] tx_byte_r;

    i2c_byte_engine u_engine (
        .mclk_i     (mclk_i),
        .rstn_i     (rstn_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .sda_o      (sda_o),
        .sda_oen_o  (sda_oen_o),
        .ack_i      (ack_r),
        .tx_en_i    (tx_en_r),
        .tx_byte_i  (tx_byte_r),
        .start_o    (start),
        .stop_o     (stop),
        .byte_o     (rx_byte),
        .byte_vld_o (byte_vld),
        .mack_o     (mack),
        .mnack_o    (mnack)
    );

    // ==========================================================
    // Transaction sequencing
    txn_state_e  state_r;
    logic [7:0]  ptr_r;
    logic [7:0]  hi_r;
    logic [7:0]  rd_lo_r;
    logic        wr_stb_r;
    logic [15:0] wr_data_r;
    logic [15:0] rd_word;
    logic        addr_hit;

    assign addr_hit = (rx_byte[7:1] == SLAVE_ADDR);

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            state_r <= TS_IDLE;
        end else if (start) begin
            state_r <= TS_DEV;
        end else if (stop) begin
            state_r <= TS_IDLE;
        end else if (byte_vld) begin
            case (state_r)
                TS_DEV:  state_r <= !addr_hit ? TS_SKIP : (rx_byte[0] ? TS_RHI : TS_REG);
                TS_REG:  state_r <= TS_WHI;
                TS_WHI:  state_r <= TS_WLO;
                TS_WLO:  state_r <= TS_SKIP;
                default: state_r <= state_r;
            endcase
        end else if (mack || mnack) begin
            case (state_r)
                TS_RHI:  state_r <= mack ? TS_RLO : TS_SKIP;
                default: state_r <= TS_SKIP;
            endcase
        end
    end

    // Bytes past the fourth of a write are not acknowledged
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            ack_r <= 1'b0;
        end else if (start || stop) begin
            ack_r <= 1'b0;
        end else if (byte_vld) begin
            ack_r <= (state_r == TS_DEV && addr_hit) || state_r == TS_REG
                     || state_r == TS_WHI || state_r == TS_WLO;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            ptr_r <= 8'h00;
            hi_r  <= 8'h00;
        end else if (byte_vld && state_r == TS_REG) begin
            ptr_r <= rx_byte;
        end else if (byte_vld && state_r == TS_WHI) begin
            hi_r  <= rx_byte;
        end
    end

    // Commit only after the low byte, so a cut write changes nothing
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            wr_stb_r  <= 1'b0;
            wr_data_r <= ZERO_WORD;
        end else begin
            wr_stb_r <= byte_vld & (state_r == TS_WLO);
            if (byte_vld && state_r == TS_WLO) begin
                wr_data_r <= {hi_r, rx_byte};
            end
        end
    end

    // Whole word is captured at the read address so both bytes agree
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            tx_en_r   <= 1'b0;
            tx_byte_r <= 8'h00;
            rd_lo_r   <= 8'h00;
        end else if (start || stop || mnack) begin
            tx_en_r   <= 1'b0;
        end else if (byte_vld && state_r == TS_DEV && addr_hit && rx_byte[0]) begin
            tx_en_r   <= 1'b1;
            tx_byte_r <= rd_word[15:8];
            rd_lo_r   <= rd_word[7:0];
        end else if (mack && state_r == TS_RHI) begin
            tx_byte_r <= rd_lo_r;
        end else if (mack) begin
            tx_en_r   <= 1'b0;
        end
    end

    // ==========================================================
    // Writable registers
    logic [15:0] bright_r;
    logic [15:0] curr_r;
    logic [15:0] cfg1_r;
    logic [15:0] cfg2_r;
    logic [15:0] sup_ien_r;
    logic [15:0] bst_ien_r;
    logic [15:0] led_ien_r;

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            bright_r  <= RST_BRIGHT;
            curr_r    <= RST_CURR;
            cfg1_r    <= RST_CFG1;
            cfg2_r    <= RST_CFG2;
            sup_ien_r <= RST_IEN;
            bst_ien_r <= RST_IEN;
            led_ien_r <= RST_IEN;
        end else if (wr_stb_r) begin
            case (ptr_r)
                OFS_BRIGHT:  bright_r  <= wr_data_r;
                OFS_CURR:    curr_r    <= wr_data_r;
                OFS_CFG1:    cfg1_r    <= wr_data_r;
                OFS_CFG2:    cfg2_r    <= wr_data_r;
                OFS_SUP_IEN: sup_ien_r <= wr_data_r;
                OFS_BST_IEN: bst_ien_r <= wr_data_r;
                OFS_LED_IEN: led_ien_r <= wr_data_r;
                default:     ;
            endcase
        end
    end

    // ==========================================================
    // Fault status
    logic [2:0] flt_wr;

    assign flt_wr = {wr_stb_r && ptr_r == OFS_LED_FLT,
                     wr_stb_r && ptr_r == OFS_BST_FLT,
                     wr_stb_r && ptr_r == OFS_SUP_FLT};

    fault_flags #(
        .GROUPS (3),
        .FLAGS  (FLAGS)
    ) u_faults (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .evt_i   ({led_fault_evt_i, boost_fault_evt_i, supply_fault_evt_i}),
        .wr_i    (flt_wr),
        .wdata_i (wr_data_r),
        .flags_o (fault_flags_o)
    );

    // ==========================================================
    // Read decode
    always_comb begin
        rd_word = ZERO_WORD;
        case (ptr_r)
            OFS_BRIGHT:    rd_word = bright_r;
            OFS_CURR:      rd_word = curr_r;
            OFS_CFG1:      rd_word = cfg1_r;
            OFS_CFG2:      rd_word = cfg2_r;
            OFS_SUP_IEN:   rd_word = sup_ien_r;
            OFS_BST_IEN:   rd_word = bst_ien_r;
            OFS_LED_IEN:   rd_word = led_ien_r;
            OFS_SUP_FLT:   rd_word[FLAGS-1:0] = fault_flags_o[FLAGS-1:0];
            OFS_BST_FLT:   rd_word[FLAGS-1:0] = fault_flags_o[2*FLAGS-1:FLAGS];
            OFS_LED_FLT:   rd_word[FLAGS-1:0] = fault_flags_o[3*FLAGS-1:2*FLAGS];
            OFS_DIAG_FSM:  rd_word = diag_state_i;
            OFS_DIAG_PWMI: rd_word = pwm_duty_i;
            OFS_DIAG_PWMO: rd_word = diag_pwm_out_i;
            OFS_DIAG_CUR:  rd_word = diag_current_i;
            OFS_DIAG_BST:  rd_word = diag_boost_i;
            OFS_DIAG_DET:  rd_word = diag_detect_i;
            default:       rd_word = ZERO_WORD;
        endcase
    end

    // ==========================================================
    // Control outputs
    // Reserved source codes give zero brightness rather than a guess
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            brightness_o <= ZERO_WORD;
        end else begin
            case (cfg1_r[SRC_LSB+1:SRC_LSB])
                SRC_PWM: brightness_o <= pwm_duty_i;
                SRC_REG: brightness_o <= bright_r;
                default: brightness_o <= ZERO_WORD;
            endcase
        end
    end

    assign global_current_setting_o   = curr_r[CUR_MSB:0];
    assign brightness_source_select_o = cfg1_r[SRC_LSB+1:SRC_LSB];
    assign smooth_sloping_on_o        = cfg1_r[SLOPE_BIT];
    assign spread_rate_select_o       = cfg1_r[RATE_LSB+1:RATE_LSB];
    assign config_one_o               = cfg1_r;
    assign config_two_o               = cfg2_r;
    assign supply_int_en_o            = sup_ien_r;
    assign boost_int_en_o             = bst_ien_r;
    assign led_interrupt_enable_o               = led_ien_r;

    // ==========================================================
    // Checks
    AST_RESET_VALUES: assert property (@(posedge mclk_i)
        $rose(rstn_i) |-> curr_r == RST_CURR && global_current_setting_o == RST_CURR[CUR_MSB:0]
            && bright_r == RST_BRIGHT)
        else $error("current or brightness reset value wrong");

    AST_CFG1_RESET: assert property (@(posedge mclk_i)
        $rose(rstn_i) |-> config_one_o == RST_CFG1 && smooth_sloping_on_o)
        else $error("configuration one reset value wrong");

    AST_BRIGHT_WRITE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        wr_stb_r && ptr_r == OFS_BRIGHT |=> bright_r == $past(wr_data_r))
        else $error("brightness word not written");

    AST_CURR_WRITE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        wr_stb_r && ptr_r == OFS_CURR |=> global_current_setting_o == $past(wr_data_r[11:0]))
        else $error("current setting not taken from low twelve bits");

    AST_UNMAPPED_READ: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ptr_r[0] || ptr_r > OFS_DIAG_DET |-> rd_word == ZERO_WORD)
        else $error("unmapped offset reads non zero");

    AST_UNMAPPED_WRITE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        wr_stb_r && (ptr_r[0] || ptr_r > OFS_DIAG_DET)
        |=> $stable(bright_r) && $stable(curr_r) && $stable(cfg1_r) && $stable(cfg2_r))
        else $error("write to unmapped offset changed a register");

    AST_SRC_REG: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        brightness_source_select_o == SRC_REG |=> brightness_o == $past(bright_r))
        else $error("register brightness source not followed");

    AST_SRC_PWM: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        brightness_source_select_o == SRC_PWM |=> brightness_o == $past(pwm_duty_i))
        else $error("PWM brightness source not followed");

    AST_WRITE_FOURTH_BYTE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        byte_vld && state_r == TS_WLO && !start && !stop
        |=> wr_stb_r && wr_data_r == {$past(hi_r), $past(rx_byte)} ##1 !wr_stb_r)
        else $error("write not committed after the fourth byte");

endmodule : led_driver_register_map

// ===== hdl/led_regs_pkg.sv
// Constants, reset values and transaction states of the LED driver register bank
package led_regs_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_BRIGHT    = 8'h00;
    localparam logic [7:0] OFS_CURR      = 8'h02;
    localparam logic [7:0] OFS_CFG1      = 8'h04;
    localparam logic [7:0] OFS_CFG2      = 8'h06;
    localparam logic [7:0] OFS_SUP_IEN   = 8'h08;
    localparam logic [7:0] OFS_BST_IEN   = 8'h0A;
    localparam logic [7:0] OFS_LED_IEN   = 8'h0C;
    localparam logic [7:0] OFS_SUP_FLT   = 8'h0E;
    localparam logic [7:0] OFS_BST_FLT   = 8'h10;
    localparam logic [7:0] OFS_LED_FLT   = 8'h12;
    localparam logic [7:0] OFS_DIAG_FSM  = 8'h14;
    localparam logic [7:0] OFS_DIAG_PWMI = 8'h16;
    localparam logic [7:0] OFS_DIAG_PWMO = 8'h18;
    localparam logic [7:0] OFS_DIAG_CUR  = 8'h1A;
    localparam logic [7:0] OFS_DIAG_BST  = 8'h1C;
    localparam logic [7:0] OFS_DIAG_DET  = 8'h1E;

    // ==========================================================
    // Reset values
    localparam logic [15:0] RST_BRIGHT = 16'h0000;
    localparam logic [15:0] RST_CURR   = 16'h0FFF;
    localparam logic [15:0] RST_CFG1   = 16'h08A3;
    localparam logic [15:0] RST_CFG2   = 16'h0100;
    localparam logic [15:0] RST_IEN    = 16'hAAAA;
    localparam logic [15:0] ZERO_WORD  = 16'h0000;

    // ==========================================================
    // Field positions and codes
    localparam int         CUR_MSB     = 11;
    localparam int         SRC_LSB     = 8;
    localparam int         RATE_LSB    = 12;
    localparam int         SLOPE_BIT   = 1;
    localparam int         CLR_LSB     = 8;
    localparam int         FLAG_MAX    = 8;
    localparam logic [1:0] SRC_PWM     = 2'h0;
    localparam logic [1:0] SRC_REG     = 2'h2;

    // ==========================================================
    // Serial link
    localparam logic [3:0] LAST_BIT    = 4'h7;
    localparam logic [3:0] ACK_SLOT    = 4'h8;
    localparam logic [6:0] SLAVE_DEF   = 7'h3A;

    typedef enum logic [2:0] {
        TS_IDLE, TS_DEV, TS_REG, TS_WHI, TS_WLO, TS_RHI, TS_RLO, TS_SKIP
    } txn_state_e;

endpackage : led_regs_pkg

// ===== verif/i2c_host_model.sv
// I2C host model that moves 16-bit values to and from the register bank
`timescale 1ns/1ns
module i2c_host_model #(
    parameter logic [6:0] DEV = 7'h00
) (
    // Clock and resolved data line
    input  wire logic mclk_i,
    input  wire logic sda_i,
    // Host pin drives
    output logic      scl_o,
    output logic      sda_oen_o
);
    initial begin
        scl_o     = 1'b1;
        sda_oen_o = 1'b1;
    end

    // ==========================================================
    // Pin timing
    // Four mclk per step keeps both pins stable beyond the three cycle minimum
    task automatic pins(input logic c, input logic d);
        scl_o     = c;
        sda_oen_o = d;
        repeat (4) @(negedge mclk_i);
    endtask : pins

    task automatic start_c();
        pins(scl_o, 1'b1);
        pins(1'b1, 1'b1);
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b0);
    endtask : start_c

    task automatic stop_c();
        pins(1'b0, 1'b0);
        pins(1'b1, 1'b0);
        pins(1'b1, 1'b1);
    endtask : stop_c

    // Data may only move while the clock is low; sampled mid high phase
    task automatic byte_x(input logic [7:0] d, input logic ai, output logic [7:0] r,
                          output logic ack);
        logic s;
        for (int i = 7; i >= -1; i--) begin
            pins(1'b0, (i < 0) ? ai : d[i]);
            pins(1'b1, (i < 0) ? ai : d[i]);
            s = sda_i;
            pins(1'b1, (i < 0) ? ai : d[i]);
            pins(1'b0, (i < 0) ? ai : d[i]);
            if (i >= 0) r[i] = s;
            else ack = ~s;
        end
    endtask : byte_x

    // ==========================================================
    // Register transfers
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [15:0] d,
                             output logic ok);
        logic [7:0] r;
        logic [3:0] k;
        start_c();
        byte_x({dev, 1'b0}, 1'b1, r, k[0]);
        byte_x(a, 1'b1, r, k[1]);
        byte_x(d[15:8], 1'b1, r, k[2]);
        byte_x(d[7:0], 1'b1, r, k[3]);
        stop_c();
        ok = &k;
    endtask : write_reg

    // High byte is acknowledged, low byte refused to end the read
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        logic [7:0] r;
        logic       k;
        start_c();
        byte_x({DEV, 1'b0}, 1'b1, r, k);
        byte_x(a, 1'b1, r, k);
        start_c();
        byte_x({DEV, 1'b1}, 1'b1, r, k);
        byte_x(8'hFF, 1'b0, d[15:8], k);
        byte_x(8'hFF, 1'b1, d[7:0], k);
        stop_c();
    endtask : read_reg
endmodule : i2c_host_model

// ===== verif/led_driver_register_map_tb.sv
// Self-checking testbench of the LED driver register bank
`timescale 1ns/1ns
module led_driver_register_map_tb
    import led_regs_pkg::*;
;
    logic        mclk;
    logic        rstn_n;
    logic        scl;
    logic        host_oen;
    logic        dut_oen;
    logic [23:0] evt;
    logic [15:0] dv [0:5];
    logic [15:0] brt;
    logic [11:0] cur;
    logic [1:0]  src;
    logic        slope;
    logic [1:0]  rate;
    logic [23:0] flags;
    logic [15:0] cf [0:1];
    logic [15:0] ie [0:2];
    logic [15:0] rd;
    logic [15:0] m;
    logic [7:0]  ofs;
    logic        ok;
    int          fails;
    int          samples_checked;
    // Open drain line with pull-up
    wire         sda = host_oen & dut_oen;

    led_driver_register_map #(.SLAVE_ADDR(SLAVE_DEF), .FLAGS(8)) dut (
        .mclk_i(mclk), .rstn_i(rstn_n), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oen_o(dut_oen), .supply_fault_evt_i(evt[7:0]), .boost_fault_evt_i(evt[15:8]),
        .led_fault_evt_i(evt[23:16]), .pwm_duty_i(dv[1]), .diag_state_i(dv[0]),
        .diag_pwm_out_i(dv[2]), .diag_current_i(dv[3]), .diag_boost_i(dv[4]),
        .diag_detect_i(dv[5]), .brightness_o(brt), .global_current_setting_o(cur),
        .brightness_source_select_o(src), .smooth_sloping_on_o(slope),
        .spread_rate_select_o(rate), .config_one_o(cf[0]), .config_two_o(cf[1]),
        .supply_int_en_o(ie[0]), .boost_int_en_o(ie[1]), .led_interrupt_enable_o(ie[2]),
        .fault_flags_o(flags));

    i2c_host_model #(.DEV(SLAVE_DEF)) host (
        .mclk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_oen_o(host_oen));

    always #4 mclk = ~mclk;

    // ==========================================================
    // Checks and transfers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.write_reg(SLAVE_DEF, a, d, ok);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        host.read_reg(a, rd);
        chk(rd, exp);
    endtask : rdc

    task automatic end_of_test();
        if (fails == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test

    // Whole run needs about 310 us; over twice that means a hang
    initial begin
        #640000;
        fails++;
        end_of_test();
    end

    // ==========================================================
    // Test sequence
    initial begin
        mclk   = 1'b0;
        rstn_n = 1'b0;
        evt    = 24'h000000;
        for (int k = 0; k < 6; k++) dv[k] = 16'(16'h1111 * (k + 1));
        repeat (4) @(negedge mclk);
        rstn_n = 1'b1;
        repeat (2) @(negedge mclk);
        rdc(OFS_BRIGHT, 16'h0000);
        rdc(OFS_CURR, 16'h0FFF);
        rdc(OFS_CFG1, 16'h08A3);
        chk(16'(cur), 16'h0FFF);
        chk(16'({rate, src, slope}), 16'h0001);
        rdc(OFS_CFG2, 16'h0100);
        chk(cf[1], 16'h0100);
        for (int g = 0; g < 3; g++) begin
            rdc(8'(8'h08 + 2 * g), 16'hAAAA);
            chk(ie[g], 16'hAAAA);
        end
        wr(OFS_BRIGHT, 16'hA5C3);
        chk(16'(ok), 16'h0001);
        rdc(OFS_BRIGHT, 16'hA5C3);
        wr(OFS_CURR, 16'hF123);
        rdc(OFS_CURR, 16'hF123);
        chk(16'(cur), 16'h0123);
        // Every source code, reserved ones included
        for (int s = 0; s < 4; s++) begin
            wr(OFS_CFG1, 16'h3002 | 16'(s << 8));
            chk(brt, (s == 0) ? dv[1] : (s == 2) ? 16'hA5C3 : 16'h0000);
            chk(16'({rate, src, slope}), 16'({2'h3, 2'(s), 1'b1}));
            chk(cf[0], 16'h3002 | 16'(s << 8));
        end
        wr(OFS_CFG2, 16'h00FF);
        rdc(OFS_CFG2, 16'h00FF);
        chk(cf[1], 16'h00FF);
        for (int g = 0; g < 3; g++) begin
            wr(8'(8'h08 + 2 * g), 16'h5555);
            chk(ie[g], 16'h5555);
        end
        // Odd and out of range offsets must leave the map untouched
        wr(8'h01, 16'h1234);
        wr(8'h20, 16'h5678);
        rdc(8'h01, 16'h0000);
        rdc(8'h20, 16'h0000);
        rdc(OFS_BRIGHT, 16'hA5C3);
        host.write_reg(SLAVE_DEF ^ 7'h01, OFS_BRIGHT, 16'h0F0F, ok);
        chk(16'(ok), 16'h0000);
        rdc(OFS_BRIGHT, 16'hA5C3);
        for (int k = 0; k < 6; k++) dv[k] = ~dv[k];
        for (int k = 0; k < 6; k++) rdc(8'(8'h14 + 2 * k), dv[k]);
        // Status alone and clear alone must not clear a flag
        for (int g = 0; g < 3; g++) begin
            ofs = 8'(8'h0E + 2 * g);
            m = 16'h0001 << (g + 2);
            evt[g * 8 + g + 2] = 1'b1;
            @(negedge mclk);
            evt = 24'h000000;
            rdc(ofs, m);
            wr(ofs, m);
            rdc(ofs, m);
            wr(ofs, m << 8);
            rdc(ofs, m);
            chk(16'(flags[g * 8 +: 8]), m);
            wr(ofs, m | (m << 8));
            rdc(ofs, 16'h0000);
            chk(16'(flags[g * 8 +: 8]), 16'h0000);
        end
        rstn_n = 1'b0;
        repeat (2) @(negedge mclk);
        rstn_n = 1'b1;
        repeat (2) @(negedge mclk);
        rdc(OFS_BRIGHT, 16'h0000);
        chk(16'(cur), 16'h0FFF);
        chk(ie[2], 16'hAAAA);
        end_of_test();
    end
endmodule : led_driver_register_map_tb
